// >>> rtl/zsfh_pkg.sv
// Purpose: Shared constants and types for zone smoothing and fan hysteresis.
// Assumes: Byte-wide register port reached through the management port decoder.
// Notes: Temperatures are signed, 1 degree per count in the integer part.
package zsfh_pkg;
  localparam int TEMP_W = 8;
  localparam int FRAC_W = 8;
  localparam logic [7:0] ADDR_BOOST_HYST = 8'hC1;
  localparam logic [7:0] ADDR_SMOOTH_CTRL = 8'hC2;
  localparam logic [7:0] ADDR_TABLE_A = 8'hC3;
  localparam logic [7:0] ADDR_TABLE_B = 8'hC4;
  localparam logic [7:0] RST_BOOST_HYST = 8'h44;
  localparam logic [7:0] RST_SMOOTH_CTRL = 8'h00;
  localparam logic [7:0] RST_TABLE_A = 8'h00;
  localparam logic [7:0] RST_TABLE_B = 8'h00;
  localparam logic [3:0] DUTY_CODE_MAX = 4'hC;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam int CLK_HZ = 100_000_000;
  // Sample tick period of the filters in ns.
  localparam int SAMPLE_NS = 100_000;
  localparam int SAMPLE_CYC = SAMPLE_NS / (1_000_000_000 / CLK_HZ);
  // Smoothing spans in milliseconds, codes 0 to 7.
  localparam int SPAN_MS [8] = '{11800, 7000, 4400, 3000, 1600, 800, 600, 400};
  // Filter shift per span code, about log2 of span over sample period.
  localparam logic [4:0] SPAN_SHIFT [8] = '{5'd17, 5'd16, 5'd15, 5'd15, 5'd14, 5'd13, 5'd13, 5'd12};

  typedef struct packed {
    logic [3:0] margin_d;
    logic [3:0] margin_c;
  } zsfh_boost_t;

  typedef struct packed {
    logic use_filtered_b;
    logic [2:0] smoothing_span_b;
    logic use_filtered_a;
    logic [2:0] smoothing_span_a;
  } zsfh_smooth_t;

  typedef struct packed {
    logic [3:0] floor_duty;
    logic [3:0] step_margin;
  } zsfh_table_t;
endpackage

// >>> rtl/zsfh_smooth.sv
// Purpose: First-order recursive average of one zone temperature.
// Assumes: Sample tick is a one-cycle pulse.
// Notes: Runs always; the selection of its output is done elsewhere.
`timescale 1ns/1ps
module zsfh_smooth #(
  parameter int TW = zsfh_pkg::TEMP_W,
  parameter int FW = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic [2:0] span,
  input wire logic signed [TW-1:0] raw,
  output logic signed [TW-1:0] filt
);
  logic signed [TW+FW-1:0] acc_ff;
  logic signed [TW+FW-1:0] nxt_acc;
  logic signed [TW+FW-1:0] diff;

  // Accumulator moves toward the raw value by diff shifted by the span.
  always_comb begin
    diff = ($signed({raw, {FW{1'b0}}}) - acc_ff) >>> zsfh_pkg::SPAN_SHIFT[span];
    nxt_acc = tick ? acc_ff + diff : acc_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt <= '0;
    end else begin
      filt <= acc_ff[TW+FW-1:FW];
    end
  end
endmodule

// >>> rtl/zsfh_boost.sv
// Purpose: Fan boost hold with release hysteresis for one zone.
// Assumes: Boost limit and temperature in whole degrees.
// Notes: Full duty asserted while above limit and until at or below limit minus margin.
`timescale 1ns/1ps
module zsfh_boost #(
  parameter int TW = zsfh_pkg::TEMP_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic signed [TW-1:0] temp,
  input wire logic signed [TW-1:0] limit,
  input wire logic [3:0] margin,
  output logic full_duty
);
  logic hold_ff;
  logic nxt_hold;
  logic signed [TW+1:0] release_at;

  always_comb begin
    release_at = (TW+2)'(limit) - (TW+2)'($signed({1'b0, margin}));
    nxt_hold = hold_ff;
    if ((TW+2)'(temp) > (TW+2)'(limit)) begin
      nxt_hold = 1'b1;
    end else if ((TW+2)'(temp) <= release_at) begin
      nxt_hold = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  assign full_duty = hold_ff;
endmodule

// >>> rtl/zsfh_top.sv
// Purpose: Registers and behaviour of zone smoothing, boost hysteresis and table floor.
// Assumes: Byte register port from the management interface decoder.
// Notes: Reads are registered one cycle after the strobe.
`timescale 1ns/1ps
module zsfh_top #(
  parameter int TW = zsfh_pkg::TEMP_W,
  parameter int SAMPLE_CYC = zsfh_pkg::SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic signed [TW-1:0] zone1a_raw,
  input wire logic signed [TW-1:0] zone1b_raw,
  input wire logic signed [TW-1:0] zone2a_raw,
  input wire logic signed [TW-1:0] zone2b_raw,
  input wire logic signed [TW-1:0] zone3_temp,
  input wire logic signed [TW-1:0] zone4_temp,
  input wire logic signed [TW-1:0] zone3_boost_limit,
  input wire logic signed [TW-1:0] zone4_boost_limit,
  input wire logic margin_res_a,
  input wire logic margin_res_b,
  output logic signed [TW-1:0] zone1a_filt,
  output logic signed [TW-1:0] zone1b_filt,
  output logic signed [TW-1:0] zone2a_filt,
  output logic signed [TW-1:0] zone2b_filt,
  output logic signed [TW-1:0] zone1a_reading,
  output logic signed [TW-1:0] zone1b_reading,
  output logic signed [TW-1:0] zone2a_reading,
  output logic signed [TW-1:0] zone2b_reading,
  output logic signed [TW-1:0] zone1a_ctrl,
  output logic signed [TW-1:0] zone1b_ctrl,
  output logic signed [TW-1:0] zone2a_ctrl,
  output logic signed [TW-1:0] zone2b_ctrl,
  output logic zone3_full_duty,
  output logic zone4_full_duty,
  output logic [3:0] table_step_margin_a,
  output logic [3:0] table_step_margin_b,
  output logic table_margin_fine_a,
  output logic table_margin_fine_b,
  output logic [3:0] table_floor_duty_a,
  output logic [3:0] table_floor_duty_b
);
  zsfh_pkg::zsfh_boost_t boost_ff, nxt_boost;
  zsfh_pkg::zsfh_smooth_t smooth_ff, nxt_smooth;
  zsfh_pkg::zsfh_table_t tab_a_ff, nxt_tab_a, tab_b_ff, nxt_tab_b;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;
  logic signed [TW-1:0] f1a, f1b, f2a, f2b;

  // Codes above the last mapped one request the highest defined duty.
  function automatic logic [3:0] floor_code(input logic [3:0] code);
    floor_code = (code > zsfh_pkg::DUTY_CODE_MAX) ? zsfh_pkg::DUTY_CODE_MAX : code;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == zsfh_pkg::ADDR_BOOST_HYST) || (a == zsfh_pkg::ADDR_SMOOTH_CTRL) ||
                 (a == zsfh_pkg::ADDR_TABLE_A) || (a == zsfh_pkg::ADDR_TABLE_B);
  endfunction

  // Register writes and read data.
  always_comb begin
    nxt_boost = boost_ff;
    nxt_smooth = smooth_ff;
    nxt_tab_a = tab_a_ff;
    nxt_tab_b = tab_b_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr) begin
      if (reg_addr == zsfh_pkg::ADDR_BOOST_HYST) begin
        nxt_boost = reg_wdata;
      end else if (reg_addr == zsfh_pkg::ADDR_SMOOTH_CTRL) begin
        nxt_smooth = reg_wdata;
      end else if (reg_addr == zsfh_pkg::ADDR_TABLE_A) begin
        nxt_tab_a = reg_wdata;
      end else if (reg_addr == zsfh_pkg::ADDR_TABLE_B) begin
        nxt_tab_b = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == zsfh_pkg::ADDR_BOOST_HYST) begin
        nxt_rdata = boost_ff;
      end else if (reg_addr == zsfh_pkg::ADDR_SMOOTH_CTRL) begin
        nxt_rdata = smooth_ff;
      end else if (reg_addr == zsfh_pkg::ADDR_TABLE_A) begin
        nxt_rdata = tab_a_ff;
      end else if (reg_addr == zsfh_pkg::ADDR_TABLE_B) begin
        nxt_rdata = tab_b_ff;
      end else begin
        nxt_rdata = zsfh_pkg::READ_NONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boost_ff <= zsfh_pkg::RST_BOOST_HYST;
      smooth_ff <= zsfh_pkg::RST_SMOOTH_CTRL;
      tab_a_ff <= zsfh_pkg::RST_TABLE_A;
      tab_b_ff <= zsfh_pkg::RST_TABLE_B;
      rdata_ff <= zsfh_pkg::READ_NONE;
    end else begin
      boost_ff <= nxt_boost;
      smooth_ff <= nxt_smooth;
      tab_a_ff <= nxt_tab_a;
      tab_b_ff <= nxt_tab_b;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_hit = (reg_wr || reg_rd) && addr_known(reg_addr);

  // Sample tick for the filters.
  always_comb begin
    tick = (tick_cnt_ff == 32'(SAMPLE_CYC - 1));
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 32'h0000_0001;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // Filters act on converted readings, as an extra stage
  zsfh_smooth #(.TW(TW)) u_f1a (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .span(smooth_ff.smoothing_span_a), .raw(zone1a_raw), .filt(f1a));
  zsfh_smooth #(.TW(TW)) u_f1b (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .span(smooth_ff.smoothing_span_a), .raw(zone1b_raw), .filt(f1b));
  zsfh_smooth #(.TW(TW)) u_f2a (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .span(smooth_ff.smoothing_span_b), .raw(zone2a_raw), .filt(f2a));
  zsfh_smooth #(.TW(TW)) u_f2b (.clk(clk), .sys_rst(sys_rst), .tick(tick),
    .span(smooth_ff.smoothing_span_b), .raw(zone2b_raw), .filt(f2b));

  assign zone1a_filt = f1a;
  assign zone1b_filt = f1b;
  assign zone2a_filt = f2a;
  assign zone2b_filt = f2b;

  // Reading outputs always show the raw values.
  assign zone1a_reading = zone1a_raw;
  assign zone1b_reading = zone1b_raw;
  assign zone2a_reading = zone2a_raw;
  assign zone2b_reading = zone2b_raw;

  // Values used for limit checks and fan control.
  assign zone1a_ctrl = smooth_ff.use_filtered_a ? f1a : zone1a_raw;
  assign zone1b_ctrl = smooth_ff.use_filtered_a ? f1b : zone1b_raw;
  assign zone2a_ctrl = smooth_ff.use_filtered_b ? f2a : zone2a_raw;
  assign zone2b_ctrl = smooth_ff.use_filtered_b ? f2b : zone2b_raw;

  // Boost hold with unsigned margins.
  zsfh_boost #(.TW(TW)) u_b3 (.clk(clk), .sys_rst(sys_rst), .temp(zone3_temp),
    .limit(zone3_boost_limit), .margin(boost_ff.margin_c), .full_duty(zone3_full_duty));
  zsfh_boost #(.TW(TW)) u_b4 (.clk(clk), .sys_rst(sys_rst), .temp(zone4_temp),
    .limit(zone4_boost_limit), .margin(boost_ff.margin_d), .full_duty(zone4_full_duty));

  // Table fields toward the lookup controller; a zero margin is allowed.
  assign table_step_margin_a = tab_a_ff.step_margin;
  assign table_step_margin_b = tab_b_ff.step_margin;
  assign table_margin_fine_a = margin_res_a;
  assign table_margin_fine_b = margin_res_b;
  assign table_floor_duty_a = floor_code(tab_a_ff.floor_duty);
  assign table_floor_duty_b = floor_code(tab_b_ff.floor_duty);
endmodule

// >>> verification/zsfh_top_sva.sv
// Purpose: Port checker for zone smoothing and fan hysteresis.
// Assumes: Only the top module ports are visible.
// Notes: Shadows of the boost and smoothing registers follow writes.
`timescale 1ns/1ps
module zsfh_top_sva #(
  parameter int TW = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic signed [TW-1:0] zone1a_raw,
  input wire logic signed [TW-1:0] zone2a_raw,
  input wire logic signed [TW-1:0] zone2b_raw,
  input wire logic signed [TW-1:0] zone3_temp,
  input wire logic signed [TW-1:0] zone4_temp,
  input wire logic signed [TW-1:0] zone3_boost_limit,
  input wire logic signed [TW-1:0] zone4_boost_limit,
  input wire logic margin_res_a,
  input wire logic margin_res_b,
  input wire logic signed [TW-1:0] zone1a_filt,
  input wire logic signed [TW-1:0] zone2a_filt,
  input wire logic signed [TW-1:0] zone1a_ctrl,
  input wire logic signed [TW-1:0] zone2a_ctrl,
  input wire logic signed [TW-1:0] zone2b_reading,
  input wire logic zone3_full_duty,
  input wire logic zone4_full_duty,
  input wire logic table_margin_fine_a,
  input wire logic table_margin_fine_b
);
  logic [7:0] c1_ff, nxt_c1, c2_ff, nxt_c2;
  logic mapped;
  int lo3, lo4;
  assign mapped = reg_addr >= zsfh_pkg::ADDR_BOOST_HYST && reg_addr <= zsfh_pkg::ADDR_TABLE_B;
  assign lo3 = int'(zone3_boost_limit) - int'(c1_ff[3:0]);
  assign lo4 = int'(zone4_boost_limit) - int'(c1_ff[7:4]);
  always_comb begin
    nxt_c1 = c1_ff;
    nxt_c2 = c2_ff;
    if (sys_rst) begin
      nxt_c1 = zsfh_pkg::RST_BOOST_HYST;
      nxt_c2 = zsfh_pkg::RST_SMOOTH_CTRL;
    end else if (reg_wr && reg_addr == zsfh_pkg::ADDR_BOOST_HYST) begin
      nxt_c1 = reg_wdata;
    end else if (reg_wr && reg_addr == zsfh_pkg::ADDR_SMOOTH_CTRL) begin
      nxt_c2 = reg_wdata;
    end
  end
  always_ff @(posedge clk) begin
    c1_ff <= nxt_c1;
    c2_ff <= nxt_c2;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_other;
    reg_rd && !mapped;
  endsequence
  sequence s_rd_boost;
    reg_rd && !reg_wr && reg_addr == zsfh_pkg::ADDR_BOOST_HYST;
  endsequence
  a_unmapped_zero: assert property (s_rd_other |=> reg_rdata == zsfh_pkg::READ_NONE)
    else $error("unmapped read not zero");
  a_hit_decode: assert property (reg_hit == ((reg_rd || reg_wr) && mapped))
    else $error("hit decode wrong");
  a_read_back: assert property (s_rd_boost |=> reg_rdata == $past(c1_ff))
    else $error("boost register read wrong");
  a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_boost_set: assert property (zone3_temp > zone3_boost_limit |=> zone3_full_duty)
    else $error("zone three boost not set");
  a_boost_hold: assert property (zone3_full_duty && int'(zone3_temp) > lo3 |=> zone3_full_duty)
    else $error("zone three boost dropped early");
  a_boost_free: assert property (int'(zone3_temp) <= lo3 |=> !zone3_full_duty)
    else $error("zone three boost not released");
  a_boost4_free: assert property (int'(zone4_temp) <= lo4 |=> !zone4_full_duty)
    else $error("zone four boost not released");
  a_ctrl_select: assert property (zone1a_ctrl == (c2_ff[3] ? zone1a_filt : zone1a_raw)
    && zone2a_ctrl == (c2_ff[7] ? zone2a_filt : zone2a_raw))
    else $error("control temperature select wrong");
  a_reading_raw: assert property (zone2b_reading == zone2b_raw)
    else $error("reading not raw");
  a_fine_pass: assert property (table_margin_fine_a == margin_res_a && table_margin_fine_b == margin_res_b)
    else $error("margin resolution wrong");
endmodule
bind zsfh_top zsfh_top_sva #(.TW(TW)) u_sva (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_hit, .zone1a_raw, .zone2a_raw, .zone2b_raw, .zone3_temp, .zone4_temp,
  .zone3_boost_limit, .zone4_boost_limit, .margin_res_a, .margin_res_b, .zone1a_filt,
  .zone2a_filt, .zone1a_ctrl, .zone2a_ctrl, .zone2b_reading, .zone3_full_duty, .zone4_full_duty,
  .table_margin_fine_a, .table_margin_fine_b);

// >>> verification/test_zone_smoothing_and_fan_hysteresis.sv
// Purpose: Self-checking bench for zone smoothing and fan hysteresis.
// Assumes: Filter tick shortened to four cycles.
// Notes: Inputs change at rising edges by non-blocking assignment.
`timescale 1ns/1ps
module test_zone_smoothing_and_fan_hysteresis;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, margin_res_a = 0, margin_res_b = 0, reg_hit;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic signed [7:0] zone1a_raw = 0, zone1b_raw = 0, zone2a_raw = 0, zone2b_raw = 0;
  logic signed [7:0] zone3_temp = 0, zone4_temp = 0, zone3_boost_limit = 40, zone4_boost_limit = 40;
  logic signed [7:0] zone1a_filt, zone1b_filt, zone2a_filt, zone2b_filt;
  logic signed [7:0] zone1a_reading, zone1b_reading, zone2a_reading, zone2b_reading;
  logic signed [7:0] zone1a_ctrl, zone1b_ctrl, zone2a_ctrl, zone2b_ctrl;
  logic zone3_full_duty, zone4_full_duty, table_margin_fine_a, table_margin_fine_b;
  logic [3:0] table_step_margin_a, table_step_margin_b, table_floor_duty_a, table_floor_duty_b;
  int num_errors = 0;
  int comparisons = 0;
  zsfh_top #(.SAMPLE_CYC(4)) dut_u (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_hit, .zone1a_raw, .zone1b_raw, .zone2a_raw, .zone2b_raw, .zone3_temp,
    .zone4_temp, .zone3_boost_limit, .zone4_boost_limit, .margin_res_a, .margin_res_b,
    .zone1a_filt, .zone1b_filt, .zone2a_filt, .zone2b_filt, .zone1a_reading, .zone1b_reading,
    .zone2a_reading, .zone2b_reading, .zone1a_ctrl, .zone1b_ctrl, .zone2a_ctrl, .zone2b_ctrl,
    .zone3_full_duty, .zone4_full_duty, .table_step_margin_a, .table_step_margin_b,
    .table_margin_fine_a, .table_margin_fine_b, .table_floor_duty_a, .table_floor_duty_b);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic bst(input logic [7:0] t3, input logic [7:0] t4, input logic e3, input logic e4);
    @(posedge clk);
    zone3_temp <= t3;
    zone4_temp <= t4;
    repeat (2) @(posedge clk);
    #1 chk(zone3_full_duty, e3);
    chk(zone4_full_duty, e4);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    rdc(zsfh_pkg::ADDR_BOOST_HYST, 8'h44);
    rdc(zsfh_pkg::ADDR_SMOOTH_CTRL, 8'h00);
    rdc(zsfh_pkg::ADDR_TABLE_A, 8'h00);
    rdc(zsfh_pkg::ADDR_TABLE_B, 8'h00);
    wr(8'hC5, 8'hFF);
    rdc(8'hC5, 8'h00);
    wr(zsfh_pkg::ADDR_BOOST_HYST, 8'h53);
    rdc(zsfh_pkg::ADDR_BOOST_HYST, 8'h53);
    bst(41, 41, 1, 1);
    bst(38, 36, 1, 1);
    bst(37, 35, 0, 0);
    bst(38, 36, 0, 0);
    wr(zsfh_pkg::ADDR_BOOST_HYST, 8'hF0);
    bst(41, 41, 1, 1);
    bst(40, 26, 0, 1);
    bst(40, 25, 0, 0);
    @(posedge clk);
    margin_res_a <= 1;
    margin_res_b <= 1;
    wr(zsfh_pkg::ADDR_TABLE_A, 8'hF7);
    wr(zsfh_pkg::ADDR_TABLE_B, 8'hC9);
    rdc(zsfh_pkg::ADDR_TABLE_A, 8'hF7);
    chk(table_step_margin_a, 4'h7);
    chk(table_margin_fine_a, 1'b1);
    chk(table_margin_fine_b, 1'b1);
    chk(table_floor_duty_a, 4'hC);
    chk(table_step_margin_b, 4'h9);
    chk(table_floor_duty_b, 4'hC);
    wr(zsfh_pkg::ADDR_TABLE_B, 8'h5E);
    chk(table_floor_duty_b, 4'h5);
    chk(table_step_margin_b, 4'hE);
    for (int c = 0; c < 8; c++) begin
      wr(zsfh_pkg::ADDR_SMOOTH_CTRL, {1'b0, c[2:0], 1'b0, c[2:0]});
      rdc(zsfh_pkg::ADDR_SMOOTH_CTRL, {1'b0, c[2:0], 1'b0, c[2:0]});
    end
    // Zones 1 get the shortest span, zones 2 the longest, filtered values unused.
    wr(zsfh_pkg::ADDR_SMOOTH_CTRL, 8'h07);
    @(posedge clk);
    zone1a_raw <= 100;
    zone1b_raw <= 100;
    zone2a_raw <= 100;
    zone2b_raw <= 100;
    repeat (8000) @(posedge clk);
    #1 chk(zone1a_filt inside {[1:99]}, 1'b1);
    chk(zone2b_filt inside {[1:99]}, 1'b1);
    chk(zone1a_filt > zone2a_filt, 1'b1);
    chk(zone1a_ctrl, 8'd100);
    chk(zone2b_ctrl, 8'd100);
    wr(zsfh_pkg::ADDR_SMOOTH_CTRL, 8'hFF);
    chk(zone1b_ctrl inside {[1:99]}, 1'b1);
    chk(zone2a_ctrl inside {[1:99]}, 1'b1);
    chk(zone1a_reading, 8'd100);
    chk(zone1b_reading, 8'd100);
    chk(zone2a_reading, 8'd100);
    chk(zone2b_reading, 8'd100);
    end_sim();
  end
endmodule
